// file: csp_edge_sync.sv
// Three-stage pin synchroniser with edge detection for the shift clock and data input.
`default_nettype none
module csp_edge_sync (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic pinIn,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } csp_sync_s;

   csp_sync_s r_q;
   csp_sync_s r_d;

   // The level only moves when the second and third stages agree.
   always_comb begin
      r_d    = r_q;
      r_d.s1 = pinIn;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      if (r_q.s2 == r_q.s3) begin
         r_d.lvl = r_q.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r_q <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   assign level = r_q.lvl;
   assign rise  = (r_q.s2 == r_q.s3) && r_q.s3 && !r_q.lvl;
   assign fall  = (r_q.s2 == r_q.s3) && !r_q.s3 && r_q.lvl;
endmodule : csp_edge_sync
`default_nettype wire

// file: csp_peer_model.sv
// Behavioural external serial peer: link clock source and data partner.
`default_nettype none
module csp_peer_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       genClk,
   input  wire logic       lsbFirst,
   input  wire logic [7:0] txByte,
   input  wire logic       lineClk,
   input  wire logic       serialOut,
   output logic            sclkDrv,
   output logic            sinDrv,
   output logic [7:0]      rxByte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prevClk = 1'b1;
   int   nFall   = 8;
   int   nRise   = 8;
   int   hold    = 0;
   initial sclkDrv = 1'b1;
   initial sinDrv = 1'b0;
   initial rxByte = 8'h00;
   // Sixteen machine cycles a period, twice the shortest one the port accepts.
   always @(posedge genClk) begin
      #3;
      repeat (8) begin
         #80 sclkDrv = 1'b0;
         #80 sclkDrv = 1'b1;
      end
   end
   always @(posedge clk) begin
      prevClk <= lineClk;
      if (go) begin
         nFall <= 0;
         nRise <= 0;
         hold  <= 0;
      end else begin
         if (prevClk && !lineClk && nFall < 8) begin
            sinDrv <= lsbFirst ? txByte[nFall] : txByte[7 - nFall];
            nFall  <= nFall + 1;
         end
         if (!prevClk && lineClk && nRise < 8) begin
            rxByte <= lsbFirst ? {serialOut, rxByte[7:1]} : {rxByte[6:0], serialOut};
            nRise  <= nRise + 1;
         end
         // Once the hold time is over the line wanders, so a stale bit never passes as data.
         if (nRise == 8 && hold < 8) hold <= hold + 1;
         else if (nRise == 8) sinDrv <= !sinDrv;
      end
   end
endmodule : csp_peer_model
`default_nettype wire

// file: csp_pkg.sv
// Package with register map, field positions and shared types of the serial shift port.
//
// Operation
// - Exactly eight bits go out and eight come in per activation, paced by shift clock.
// - Each outgoing bit is driven onto the serial output on a falling shift edge.
// - The serial input is sampled into the data register on a rising shift edge.
// - Bit order select picks least-significant or most-significant bit first.
// - Clock source codes 000B to 100B select the internal shift clock.
// - Clock source code 101B takes the shift clock from the clock pin.
// - A clock toggled by software through the pin is accepted in external mode.
// - Writing start with stop zero activates the port; mode zero begins a transfer, mode one enters standby.
// - After a byte the done flag sets; mode zero stops, mode one waits standby.
// - Stop during a transfer aborts it, keeps done clear, enters stop state.
// - With mode zero, a start write restarts after completion.
// - With mode one, a data register read or write restarts from standby.
// - After forced stop in mode one, restart needs stop zero, start one, data access.
// - Reset and a stop write both put the port into the stop state.
// - Entering stop clears the bit counter; reset or a stop write also clears the done flag.
// - Stop overrides start; no transfer begins while stop is one.
// - Normal end clears busy, sets done and reinitializes the bit counter.
// - An interrupt request is raised at transfer end when done interrupt is enabled.
// - Busy is one during a transfer and zero in stop and standby.
`default_nettype none
package csp_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DATA = 12'h004;
   localparam logic [11:0] ADDR_PORT = 12'h008;
   localparam int          ADDR_W    = 12;

   localparam int BIT_SEL_HI  = 15;
   localparam int BIT_SEL_LO  = 13;
   localparam int BIT_DONEIE  = 12;
   localparam int BIT_DONE    = 11;
   localparam int BIT_BUSY    = 10;
   localparam int BIT_STOP    = 9;
   localparam int BIT_START   = 8;
   localparam int BIT_MODE    = 3;
   localparam int BIT_ORDER   = 2;
   localparam int BIT_CLKOE   = 1;
   localparam int BIT_PORTCLK = 0;

   localparam logic [2:0] SEL_INT_MAX = 3'h4;
   localparam logic [2:0] SEL_EXT     = 3'h5;
   localparam logic [3:0] BITS_PER_XFER = 4'h8;
   localparam logic [5:0] DIV_M_MAX   = 6'h3F;

   typedef enum logic [2:0] {
      ST_STOP    = 3'b001,
      ST_STANDBY = 3'b010,
      ST_XFER    = 3'b100
   } csp_state_e;

   typedef struct packed {
      logic [2:0] clkSel;
      logic       doneIrqEn;
      logic       stopReq;
      logic       startReq;
      logic       mode;
      logic       lsbFirst;
      logic       clkOutEn;
      logic       portClk;
   } csp_ctrl_s;
endpackage : csp_pkg
`default_nettype wire

// file: csp_shift_port.sv
// Eight-bit clocked serial shift port with an APB register slave.
`default_nettype none
module csp_shift_port #(
   parameter int XFER_BITS = 8
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        shiftClkIn,
   output logic             shiftClkOut,
   output logic             shiftClkOe_n,
   input  wire logic        serialIn,
   output logic             serialOut,
   output logic             doneIrq
);
   typedef struct packed {
      csp_pkg::csp_state_e  state;
      csp_pkg::csp_ctrl_s   ctrl;
      logic                 done;
      logic [7:0]           data;
      logic [3:0]           bitCnt;
      logic [5:0]           divCnt;
      logic                 intClk;
      logic                 sOut;
      logic                 sckOut;
      logic                 sckOe_n;
      logic                 irq;
      logic                 ready;
      logic [31:0]          rdata;
      logic                 slvErr;
   } csp_reg_s;

   csp_reg_s r_q;
   csp_reg_s r_d;

   logic extRise;
   logic extFall;
   logic sinLvl;
   logic shRise;
   logic shFall;
   logic isExt;
   logic access;
   logic dataAcc;
   logic ctrlWr;
   logic [15:0] ctrlRd;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_a);
      return a == reg_a;
   endfunction : hit

   csp_edge_sync u_sck (
      .clk   (clk),
      .srst  (srst),
      .pinIn (shiftClkIn),
      .level (),
      .rise  (extRise),
      .fall  (extFall)
   );

   csp_edge_sync u_sin (
      .clk   (clk),
      .srst  (srst),
      .pinIn (serialIn),
      .level (sinLvl),
      .rise  (),
      .fall  ()
   );

   // Ready answers the access phase one cycle late, so every transfer waits one state.
   assign access  = psel && penable && r_q.ready;
   assign dataAcc = access && hit(paddr, csp_pkg::ADDR_DATA);
   assign ctrlWr  = access && pwrite && hit(paddr, csp_pkg::ADDR_CTRL);
   assign isExt   = (r_q.ctrl.clkSel == csp_pkg::SEL_EXT);

   // The internal clock idles high, so its edges line up with an external idle-high clock.
   assign shRise = isExt ? extRise : (r_q.state == csp_pkg::ST_XFER)
                   && !r_q.intClk && r_q.divCnt == 6'h00;
   assign shFall = isExt ? extFall : (r_q.state == csp_pkg::ST_XFER)
                   && r_q.intClk && r_q.divCnt == 6'h00;

   always_comb begin
      ctrlRd = 16'h0000;
      ctrlRd[csp_pkg::BIT_SEL_HI:csp_pkg::BIT_SEL_LO] = r_q.ctrl.clkSel;
      ctrlRd[csp_pkg::BIT_DONEIE]  = r_q.ctrl.doneIrqEn;
      ctrlRd[csp_pkg::BIT_DONE]    = r_q.done;
      ctrlRd[csp_pkg::BIT_BUSY]    = (r_q.state == csp_pkg::ST_XFER);
      ctrlRd[csp_pkg::BIT_STOP]    = r_q.ctrl.stopReq;
      ctrlRd[csp_pkg::BIT_MODE]    = r_q.ctrl.mode;
      ctrlRd[csp_pkg::BIT_ORDER]   = r_q.ctrl.lsbFirst;
      ctrlRd[csp_pkg::BIT_CLKOE]   = r_q.ctrl.clkOutEn;
      ctrlRd[csp_pkg::BIT_PORTCLK] = r_q.ctrl.portClk;
   end

   always_comb begin
      r_d          = r_q;
      r_d.irq      = 1'b0;
      r_d.ready    = psel && penable && !r_q.ready;
      r_d.slvErr   = 1'b0;
      r_d.ctrl.startReq = 1'b0;

      // Read data and refusal load with ready, so they stand while pready is high.
      if (psel && penable && !r_q.ready) begin
         r_d.rdata = 32'h0000_0000;
         if (hit(paddr, csp_pkg::ADDR_CTRL)) begin
            r_d.rdata[15:0] = ctrlRd;
         end else if (hit(paddr, csp_pkg::ADDR_DATA)) begin
            r_d.rdata[7:0] = r_q.data;
         end else begin
            r_d.slvErr = 1'b1;
         end
      end
      if (ctrlWr) begin
         r_d.ctrl.clkSel    = pwdata[csp_pkg::BIT_SEL_HI:csp_pkg::BIT_SEL_LO];
         r_d.ctrl.doneIrqEn = pwdata[csp_pkg::BIT_DONEIE];
         r_d.ctrl.stopReq   = pwdata[csp_pkg::BIT_STOP];
         r_d.ctrl.startReq  = pwdata[csp_pkg::BIT_START];
         r_d.ctrl.mode      = pwdata[csp_pkg::BIT_MODE];
         r_d.ctrl.lsbFirst  = pwdata[csp_pkg::BIT_ORDER];
         r_d.ctrl.clkOutEn  = pwdata[csp_pkg::BIT_CLKOE];
         r_d.ctrl.portClk   = pwdata[csp_pkg::BIT_PORTCLK];
         // Writing zero to the done bit clears it in mode zero.
         if (!pwdata[csp_pkg::BIT_DONE] && !r_q.ctrl.mode) begin
            r_d.done = 1'b0;
         end
      end
      if (dataAcc && pwrite) begin
         r_d.data = pwdata[7:0];
      end
      if (dataAcc && r_q.ctrl.mode) begin
         r_d.done = 1'b0;
      end

      // Internal half-period divider.
      if (r_q.state == csp_pkg::ST_XFER && !isExt) begin
         if (r_q.divCnt == 6'h00) begin
            r_d.divCnt = csp_pkg::DIV_M_MAX >> (3'h5 - {2'b00, r_q.ctrl.clkSel[0]});
            r_d.intClk = !r_q.intClk;
         end else begin
            r_d.divCnt = r_q.divCnt - 6'h01;
         end
      end else begin
         r_d.divCnt = 6'h00;
         r_d.intClk = 1'b1;
      end

      case (r_q.state)
         csp_pkg::ST_STOP: begin
            r_d.bitCnt = 4'h0;
            if (ctrlWr && pwdata[csp_pkg::BIT_START] && !pwdata[csp_pkg::BIT_STOP]) begin
               if (!pwdata[csp_pkg::BIT_MODE]) begin
                  r_d.state = csp_pkg::ST_XFER;
               end else begin
                  r_d.state = csp_pkg::ST_STANDBY;
               end
            end
         end
         csp_pkg::ST_STANDBY: begin
            if (dataAcc && !r_q.ctrl.stopReq) begin
               r_d.state = csp_pkg::ST_XFER;
            end
         end
         csp_pkg::ST_XFER: begin
            if (shFall) begin
               r_d.sOut = r_q.ctrl.lsbFirst ? r_q.data[0] : r_q.data[7];
            end
            if (shRise) begin
               r_d.data = r_q.ctrl.lsbFirst ? {sinLvl, r_q.data[7:1]}
                                            : {r_q.data[6:0], sinLvl};
               r_d.bitCnt = r_q.bitCnt + 4'h1;
               if (r_q.bitCnt == 4'(XFER_BITS - 1)) begin
                  r_d.bitCnt = 4'h0;
                  r_d.done   = 1'b1;
                  r_d.irq    = r_q.ctrl.doneIrqEn;
                  r_d.state  = r_q.ctrl.mode ? csp_pkg::ST_STANDBY
                                             : csp_pkg::ST_STOP;
               end
            end
         end
         default: begin
            r_d.state = csp_pkg::ST_STOP;
         end
      endcase

      // Stop wins over start and over a completing byte.
      if (r_d.ctrl.stopReq) begin
         r_d.state  = csp_pkg::ST_STOP;
         r_d.bitCnt = 4'h0;
         r_d.done   = 1'b0;
         r_d.irq    = 1'b0;
      end

      // With the enable off the pin is left to the peer; with it on the pin carries the
      // internal clock, or the software port level in external mode. The internal clock
      // is taken from its next value so the pin and the shift edges stay in step.
      r_d.sckOe_n = !r_q.ctrl.clkOutEn;
      r_d.sckOut  = isExt ? r_q.ctrl.portClk : r_d.intClk;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r_q         <= '0;
         r_q.state   <= csp_pkg::ST_STOP;
         r_q.intClk  <= 1'b1;
         r_q.sckOut  <= 1'b1;
         r_q.sckOe_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign pready       = r_q.ready;
   assign prdata       = r_q.rdata;
   assign pslverr      = r_q.slvErr;
   assign shiftClkOut  = r_q.sckOut;
   assign shiftClkOe_n = r_q.sckOe_n;
   assign serialOut    = r_q.sOut;
   assign doneIrq      = r_q.irq;
endmodule : csp_shift_port
`default_nettype wire

// file: csp_shift_port_props.sv
// Port timing checker of the serial shift port.
`default_nettype none
module csp_shift_port_props #(
   parameter int XFER_BITS = 8
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        shiftClkIn,
   input wire logic        shiftClkOut,
   input wire logic        shiftClkOe_n,
   input wire logic        serialOut,
   input wire logic        doneIrq
);
   logic [5:0] clkHist_q;
   always_ff @(posedge clk) clkHist_q <= {clkHist_q[4:0], shiftClkIn};
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late");
   ready_once_a: assert property (pready |=> !pready) else $error("ready held");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("refusal");
   irq_pulse_a: assert property (doneIrq |=> !doneIrq) else $error("irq held");
   irq_end_a: assert property (doneIrq |-> shiftClkIn) else $error("irq mid byte");
   // Data may only move within a few cycles of a low clock, never deep in a high phase.
   out_fall_a: assert property ($changed(serialOut) |-> {clkHist_q[4:0], shiftClkIn} != 6'h3F)
      else $error("data moved on high clock");
   rst_idle_a: assert property ($fell(srst) |-> !pready && !doneIrq && shiftClkOe_n
      && shiftClkOut) else $error("reset values");
   ready_req_a: assert property (pready |-> psel && penable) else $error("stray ready");
endmodule : csp_shift_port_props
bind csp_shift_port csp_shift_port_props #(.XFER_BITS(XFER_BITS)) chk_u (.clk(clk),
   .srst(srst), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .shiftClkIn(shiftClkIn), .shiftClkOut(shiftClkOut),
   .shiftClkOe_n(shiftClkOe_n), .serialOut(serialOut), .doneIrq(doneIrq));
`default_nettype wire

// file: csp_shift_port_test.sv
// Self-checking bench of the serial shift port: table rows, then stop and mode cases.
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s exp %0h seen %0h", nm, ex, gt); end end
module csp_shift_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] AC = csp_pkg::ADDR_CTRL;
   localparam logic [11:0] AD = csp_pkg::ADDR_DATA;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        pready, pslverr, sclkOut, sclkOe_n, serialOut, doneIrq, sclkDrv, sinDrv;
   logic        err, pinClk, go = 1'b0, genClk = 1'b0, lsb = 1'b0;
   logic [7:0]  rxByte, txByte = 8'h00;
   int          error_cnt = 0, n_checks = 0, cycles = 0, irqCnt = 0;
   logic [19:0] rows [7] = '{20'h11300, 20'h2A55C, 20'h53C0F, 20'h681F0, 20'h97E33,
                             20'hBC45A, 20'hA2B96};
   assign pinClk = sclkOe_n ? sclkDrv : sclkOut;
   csp_shift_port dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .shiftClkIn(pinClk), .shiftClkOut(sclkOut),
      .shiftClkOe_n(sclkOe_n), .serialIn(sinDrv), .serialOut(serialOut), .doneIrq(doneIrq));
   csp_peer_model peer_u (.clk(clk), .go(go), .genClk(genClk), .lsbFirst(lsb),
      .txByte(txByte), .lineClk(pinClk), .serialOut(serialOut), .sclkDrv(sclkDrv),
      .sinDrv(sinDrv), .rxByte(rxByte));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (doneIrq === 1'b1) irqCnt++;
      if (cycles == 40000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   function automatic logic [31:0] cw(logic [2:0] s, logic m, logic l, logic oe, logic st,
                                      logic sp, logic pc);
      return {16'h0000, s, 1'b1, 2'b00, sp, st, 4'h0, m, l, oe, pc};
   endfunction : cw
   task automatic wait_irq(input int n);
      for (int i = 0; i < 3000 && irqCnt == n; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : wait_irq
   task automatic run(input logic [19:0] r, input logic m);
      logic [2:0] s;
      logic       ext;
      logic       oe;
      int         n;
      s = r[19:17];
      ext = (s == csp_pkg::SEL_EXT);
      // External rows sent LSB first clock the pin from software, other external rows from the peer, internal rows from the port.
      oe = !ext || r[16];
      n = irqCnt;
      lsb    <= r[16];
      txByte <= r[7:0];
      go     <= 1'b1;
      apb(1'b1, AC, cw(s, m, r[16], oe, 1'b0, 1'b0, 1'b1));
      go     <= 1'b0;
      apb(1'b1, m ? AC : AD, m ? cw(s, m, r[16], oe, 1'b1, 1'b0, 1'b1) : {24'h0, r[15:8]});
      if (m) begin
         apb(1'b0, AC, 32'h0);
         `CHK("standby busy", 1'b0, rdv[10])
      end
      apb(1'b1, m ? AD : AC, m ? {24'h0, r[15:8]} : cw(s, m, r[16], oe, 1'b1, 1'b0, 1'b1));
      if (ext && sclkOe_n) begin
         genClk <= 1'b1;
         @(posedge clk);
         genClk <= 1'b0;
      end else if (ext) begin
         for (int k = 0; k < 16; k++) begin
            apb(1'b1, AC, cw(s, m, r[16], 1'b1, 1'b0, 1'b0, k[0]));
            repeat (4) @(posedge clk);
         end
      end
      wait_irq(n);
      `CHK("irq", n + 1, irqCnt)
      `CHK("tx byte", r[15:8], rxByte)
      if (ext) begin
         apb(1'b0, AD, 32'h0);
         `CHK("rx byte", r[7:0], rdv[7:0])
      end
      apb(1'b0, AC, 32'h0);
      `CHK("done busy", 2'b10, rdv[11:10])
      if (!m) apb(1'b1, AC, cw(s, m, r[16], oe, 1'b0, 1'b0, 1'b1));
   endtask : run
   initial begin
      int n;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      apb(1'b0, AC, 32'h0);
      `CHK("reset state", 2'b00, rdv[11:10])
      apb(1'b0, 12'hFFC, 32'h0);
      `CHK("refused", 1'b1, err)
      foreach (rows[i]) begin
         run(rows[i], 1'b0);
         $display("row %0d done", i);
      end
      n = irqCnt;
      apb(1'b1, AC, cw(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
      repeat (60) @(posedge clk);
      apb(1'b0, AC, 32'h0);
      `CHK("stop wins", 2'b00, rdv[11:10])
      `CHK("stop no irq", n, irqCnt)
      apb(1'b1, AC, cw(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
      apb(1'b1, AC, cw(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
      repeat (6) @(posedge clk);
      apb(1'b0, AC, 32'h0);
      `CHK("busy", 1'b1, rdv[10])
      apb(1'b1, AC, cw(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1));
      apb(1'b0, AC, 32'h0);
      `CHK("aborted", 2'b00, rdv[11:10])
      repeat (100) @(posedge clk);
      `CHK("abort no irq", n, irqCnt)
      run(20'h76D4B, 1'b0);
      $display("abort done");
      run(20'h6B2C3, 1'b1);
      n = irqCnt;
      apb(1'b0, AD, 32'h0);
      wait_irq(n);
      `CHK("read restart", n + 1, irqCnt)
      $display("mode one done");
      stop_test();
   end
endmodule : csp_shift_port_test
`default_nettype wire
